// ==== design/isr_pkg.sv ====
// Shared constants, enumerations and carriers of the instrument status reporting block.
// Assumes a 25 MHz core clock and one status set per remote interface instance.
package isr_pkg;

  // Sizes of the status model
  localparam int NUM_IF  = 5;                        // Serial, USB, GPIB, web page, socket
  localparam int IF_W    = 3;
  localparam int NUM_OUT = 4;
  localparam int OUT_W   = 2;

  // Timing
  localparam longint CLK_HZ            = 25000000;
  localparam longint VERIFY_TIMEOUT_MS = 5000;      // Verify settle limit, 5 secs
  localparam int     VERIFY_CYCLES     = int'((VERIFY_TIMEOUT_MS * CLK_HZ) / 1000);
  localparam int     VCNT_W            = 27;

  // Limit event bit positions
  localparam int LSR_FAULT_BIT = 6;
  localparam int LSR_OTEMP_BIT = 4;
  localparam int LSR_OCURR_BIT = 3;
  localparam int LSR_OVOLT_BIT = 2;
  localparam int LSR_CC_BIT    = 1;
  localparam int LSR_CV_BIT    = 0;

  // Standard event bit positions
  localparam int ESR_PON_BIT  = 7;
  localparam int ESR_CME_BIT  = 5;
  localparam int ESR_EXE_BIT  = 4;
  localparam int ESR_VTO_BIT  = 3;
  localparam int ESR_QYE_BIT  = 2;
  localparam int ESR_OPC_BIT  = 0;

  // Status byte bit positions
  localparam int STB_MSS_BIT = 6;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MAV_BIT = 4;

  // Reset values and fixed-zero masks
  localparam logic [7:0] LSR_RESET = 8'h00;
  localparam logic [7:0] LSE_RESET = 8'h00;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic [7:0] EER_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] LSR_MASK  = 8'h5F;         // Bits 7 and 5 reserved
  localparam logic [7:0] ESR_MASK  = 8'hBD;         // Bits 6 and 1 always zero
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Execution error codes
  localparam logic [7:0] EER_NONE     = 8'h00;
  localparam logic [7:0] EER_NUMERIC  = 8'h64;      // 100
  localparam logic [7:0] EER_RECALL   = 8'h66;      // 102
  localparam logic [7:0] EER_INVALID  = 8'h67;      // 103
  localparam logic [7:0] EER_DENIED   = 8'hC8;      // 200

  // Register operations issued by the command parser
  typedef enum logic [3:0] {
    OP_NONE   = 4'b0000,
    OP_RD_LSR = 4'b0001,
    OP_WR_LSE = 4'b0010,
    OP_RD_LSE = 4'b0011,
    OP_RD_ESR = 4'b0100,
    OP_WR_ESE = 4'b0101,
    OP_RD_ESE = 4'b0110,
    OP_RD_EER = 4'b0111,
    OP_WR_EER = 4'b1000,
    OP_RD_STB = 4'b1001,
    OP_SPOLL  = 4'b1010,
    OP_WR_SRE = 4'b1011,
    OP_RD_SRE = 4'b1100
  } isr_op_type;

  // One register access
  typedef struct packed {
    logic              valid;
    logic [IF_W-1:0]   inst;
    isr_op_type        op;
    logic [OUT_W-1:0]  out_sel;
    logic [7:0]        wdata;
  } isr_cmd_type;

  // Per-output hardware limit events, one-cycle pulses
  typedef struct packed {
    logic fault_trip;
    logic over_temp;
    logic over_curr;
    logic over_volt;
    logic cc_entry;
    logic cv_entry;
  } isr_limit_evt_type;

  // Per-interface parser and formatter events, one-cycle pulses
  typedef struct packed {
    logic syntax_err;
    logic query_err;
    logic opc;
    logic verify_start;
    logic verify_reached;
    logic rsp_ready;
    logic rsp_sent;
  } isr_if_evt_type;

  // Limit events placed at their register positions
  function automatic logic [7:0] isr_lsr_bits(input isr_limit_evt_type e);
    logic [7:0] v;
    v = ZERO_BYTE;
    v[LSR_FAULT_BIT] = e.fault_trip;
    v[LSR_OTEMP_BIT] = e.over_temp;
    v[LSR_OCURR_BIT] = e.over_curr;
    v[LSR_OVOLT_BIT] = e.over_volt;
    v[LSR_CC_BIT]    = e.cc_entry;
    v[LSR_CV_BIT]    = e.cv_entry;
    return v;
  endfunction : isr_lsr_bits

endpackage : isr_pkg

// ==== design/isr_verify_timer.sv ====
// Settle timer for one interface: expires when a verified setting misses its deadline.
// Assumes start and reached are one-cycle pulses from the setting logic.
`timescale 1ns/1ps
module isr_verify_timer #(
  parameter int TIMEOUT_CYCLES = isr_pkg::VERIFY_CYCLES
) (
  input  wire logic core_clk,   // Core clock
  input  wire logic rst,        // Synchronous reset, high
  input  wire logic start,      // Verified setting issued
  input  wire logic reached,    // Setting reached its value
  output logic      expired     // Pulse on timeout
);

  localparam logic [isr_pkg::VCNT_W-1:0] LOAD = isr_pkg::VCNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [isr_pkg::VCNT_W-1:0] CNT_ZERO = '0;
  localparam logic [isr_pkg::VCNT_W-1:0] CNT_ONE  = isr_pkg::VCNT_W'(1);

  logic                      running;
  logic [isr_pkg::VCNT_W-1:0] count;

  wire last = running && (count == CNT_ZERO) && !reached;

  // Count down while waiting; a new start restarts the wait
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      running <= 1'b0;
      count   <= CNT_ZERO;
      expired <= 1'b0;
    end
    else
    begin
      expired <= last;
      if (start)
      begin
        running <= 1'b1;
        count   <= LOAD;
      end
      else if (reached || last)
      begin
        running <= 1'b0;
      end
      else if (running)
      begin
        count <= count - CNT_ONE;
      end
    end
  end

endmodule : isr_verify_timer

// ==== design/isr_status_top.sv ====
// Status and error reporting model: limit, standard event, execution error and status byte.
// Assumes the command parser presents one decoded register access per cycle,
// that hardware limit events and parser events arrive as one-cycle pulses,
// and that all inputs are synchronous to core_clk.
`timescale 1ns/1ps

// Notes on behaviour
// - Each interface instance keeps its own full copy of status registers.
// - Limit events set bits 6,4,3,2,1,0; bits 7 and 5 stay zero.
// - Output summary set when any limit bit meets its enable bit.
// - Output 1 to 4 summaries sit at status byte bits 0 to 3.
// - Limit register read returns then clears; limit enable writable and readable.
// - Standard event bits 7,5,4,3,2,0 set by their events; 6,1 zero.
// - Verified setting missing its value in 5 secs sets verify timeout.
// - Syntax error sets command error, resets parser, parsing resumes.
// - Standard event read returns value then clears; power-up value 128.
// - Standard event enable takes 0-255, reads back, cleared at power-up.
// - Status bit 5 set when any standard event meets its enable.
// - Execution error code holds last error: 0,100,102,103,200.
// - Execution error read returns then clears; zero at power-up.
// - Non-zero execution error write sets standard event bit 4.
// - Bit 6 and service request raised when enabled status bits set.
// - Bit 6 is summary on query, request flag on poll; poll clears flag.
// - Message-available set on formatted response, cleared after terminator sent.
// - Status byte bit 7 always reads zero.
// - Status byte and service request enable are zero after power-up.
module isr_status_top #(
  parameter int VERIFY_CYCLES = isr_pkg::VERIFY_CYCLES
) (
  input  wire logic                                     core_clk,      // Core clock
  input  wire logic                                     rst,           // Sync reset, high
  input  wire isr_pkg::isr_cmd_type                     cmd,           // Register access
  input  wire isr_pkg::isr_limit_evt_type [isr_pkg::NUM_OUT-1:0] limit_evt, // Per output
  input  wire isr_pkg::isr_if_evt_type [isr_pkg::NUM_IF-1:0]   if_evt,    // Per interface
  output logic [7:0]                                    rsp_data,      // Read value
  output logic                                          rsp_valid,     // Read value valid
  output logic [isr_pkg::NUM_IF-1:0]                    srq,           // Service request
  output logic [isr_pkg::NUM_IF-1:0]                    parser_reset   // Parser reset pulse
);

  localparam int NI = isr_pkg::NUM_IF;
  localparam int NO = isr_pkg::NUM_OUT;

  // Limit events positioned once, shared by every interface copy
  logic [NO-1:0][7:0] lim_set;

  genvar go;
  generate
    for (go = 0; go < NO; go++)
    begin : g_lim_set
      assign lim_set[go] = isr_pkg::isr_lsr_bits(limit_evt[go]) & isr_pkg::LSR_MASK;
    end
  endgenerate

  // Read value offered by each interface copy
  logic [NI-1:0][7:0] rd_val;

  // Operation classes
  wire is_read = (cmd.op == isr_pkg::OP_RD_LSR) || (cmd.op == isr_pkg::OP_RD_LSE) ||
                 (cmd.op == isr_pkg::OP_RD_ESR) || (cmd.op == isr_pkg::OP_RD_ESE) ||
                 (cmd.op == isr_pkg::OP_RD_EER) || (cmd.op == isr_pkg::OP_RD_STB) ||
                 (cmd.op == isr_pkg::OP_SPOLL)  || (cmd.op == isr_pkg::OP_RD_SRE);
  // Instance numbers above the last copy are refused: no answer, no state change
  wire inst_ok = (cmd.inst < isr_pkg::IF_W'(NI));
  wire next_rsp_valid = cmd.valid && is_read && inst_ok;
  wire [7:0] next_rsp_data = inst_ok ? rd_val[cmd.inst] : isr_pkg::ZERO_BYTE;

  // Response register, one cycle after the access
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_data  <= isr_pkg::ZERO_BYTE;
    end
    else
    begin
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_valid ? next_rsp_data : isr_pkg::ZERO_BYTE;
    end
  end

  // One complete status model per interface instance
  genvar gi;
  genvar gj;
  generate
    for (gi = 0; gi < NI; gi++)
    begin : g_if
      logic [NO-1:0][7:0] lsr;
      logic [NO-1:0][7:0] lse;
      logic [NO-1:0]      lim_sum;
      logic [1:0][7:0]    lim_rd;
      logic [7:0]         standard_event_status;
      logic [7:0]         standard_event_enable;
      logic [7:0]         execution_error_code;
      logic [7:0]         service_request_enable;
      logic               mav;
      logic               rqs;
      logic               mss_q;
      logic               vto;

      // Access decode for this instance
      wire sel    = cmd.valid && (cmd.inst == isr_pkg::IF_W'(gi));
      wire rd_esr = sel && (cmd.op == isr_pkg::OP_RD_ESR);
      wire wr_ese = sel && (cmd.op == isr_pkg::OP_WR_ESE);
      wire rd_eer = sel && (cmd.op == isr_pkg::OP_RD_EER);
      wire wr_eer = sel && (cmd.op == isr_pkg::OP_WR_EER);
      wire wr_sre = sel && (cmd.op == isr_pkg::OP_WR_SRE);
      wire spoll  = sel && (cmd.op == isr_pkg::OP_SPOLL);

      // Verify settle timer
      isr_verify_timer #(
        .TIMEOUT_CYCLES (VERIFY_CYCLES)
      ) u_vtimer (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (if_evt[gi].verify_start),
        .reached  (if_evt[gi].verify_reached),
        .expired  (vto)
      );

      // Limit event and enable registers per output
      for (gj = 0; gj < NO; gj++)
      begin : g_out
        wire rd_lsr = sel && (cmd.op == isr_pkg::OP_RD_LSR) &&
                      (cmd.out_sel == isr_pkg::OUT_W'(gj));
        wire wr_lse = sel && (cmd.op == isr_pkg::OP_WR_LSE) &&
                      (cmd.out_sel == isr_pkg::OUT_W'(gj));

        // Read clears, a new event in the same cycle survives
        always_ff @(posedge core_clk)
        begin
          if (rst)
          begin
            lsr[gj] <= isr_pkg::LSR_RESET;
            lse[gj] <= isr_pkg::LSE_RESET;
          end
          else
          begin
            lsr[gj] <= (rd_lsr ? isr_pkg::ZERO_BYTE : lsr[gj]) | lim_set[gj];
            if (wr_lse)
            begin
              lse[gj] <= cmd.wdata;
            end
          end
        end

        assign lim_sum[gj] = |(lsr[gj] & lse[gj]);
      end

      // Selected output's registers for reads
      assign lim_rd[0] = lsr[cmd.out_sel];
      assign lim_rd[1] = lse[cmd.out_sel];

      // Standard event sources at their bit positions
      logic [7:0] esr_set;
      always_comb
      begin
        esr_set = isr_pkg::ZERO_BYTE;
        esr_set[isr_pkg::ESR_CME_BIT] = if_evt[gi].syntax_err;
        esr_set[isr_pkg::ESR_EXE_BIT] = wr_eer && (cmd.wdata != isr_pkg::EER_NONE);
        esr_set[isr_pkg::ESR_VTO_BIT] = vto;
        esr_set[isr_pkg::ESR_QYE_BIT] = if_evt[gi].query_err;
        esr_set[isr_pkg::ESR_OPC_BIT] = if_evt[gi].opc;
      end

      // Status byte summaries, recomputed from live contents
      wire       esb = |(standard_event_status & standard_event_enable);
      wire [7:0] stb_base = {1'b0, 1'b0, esb, mav, lim_sum};
      wire       mss = |(stb_base & service_request_enable);
      wire [7:0] stb_query = {1'b0, mss, stb_base[5:0]};
      wire [7:0] stb_poll  = {1'b0, rqs, stb_base[5:0]};
      // Request flag is set only on a rising summary, so a poll that clears it
      // does not see it come straight back while the condition still holds
      wire       next_rqs  = (mss && !mss_q) || (rqs && !spoll);

      // Standard event register: read clears, a new event in the same cycle survives
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          standard_event_status <= isr_pkg::ESR_RESET;
        end
        else
        begin
          standard_event_status <= ((rd_esr ? isr_pkg::ZERO_BYTE : standard_event_status) | esr_set) & isr_pkg::ESR_MASK;
        end
      end

      // Message-available and request flags; a set beats a clear in one cycle
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          mav   <= 1'b0;
          rqs   <= 1'b0;
          mss_q <= 1'b0;
        end
        else
        begin
          mav   <= if_evt[gi].rsp_ready || (mav && !if_evt[gi].rsp_sent);
          rqs   <= next_rqs;
          mss_q <= mss;
        end
      end

      // Event enable mask, any value 0 to 255
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          standard_event_enable <= isr_pkg::ESE_RESET;
        end
        else if (wr_ese)
        begin
          standard_event_enable <= cmd.wdata;
        end
      end

      // Service request enable mask; bits 6 and 7 are stored but select nothing
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          service_request_enable <= isr_pkg::SRE_RESET;
        end
        else if (wr_sre)
        begin
          service_request_enable <= cmd.wdata;
        end
      end

      // Execution error code: a write beats a read clear in the same cycle
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          execution_error_code <= isr_pkg::EER_RESET;
        end
        else if (wr_eer)
        begin
          execution_error_code <= cmd.wdata;
        end
        else if (rd_eer)
        begin
          execution_error_code <= isr_pkg::EER_NONE;
        end
      end

      // Service request output, loaded from next_rqs like the request flag, so the two match every cycle
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          srq[gi] <= 1'b0;
        end
        else
        begin
          srq[gi] <= next_rqs;
        end
      end

      // Parser reset pulse, one cycle after the syntax error
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          parser_reset[gi] <= 1'b0;
        end
        else
        begin
          parser_reset[gi] <= if_evt[gi].syntax_err;
        end
      end

      // Read value for this instance
      always_comb
      begin
        case (cmd.op)
          isr_pkg::OP_RD_LSR: rd_val[gi] = lim_rd[0];
          isr_pkg::OP_RD_LSE: rd_val[gi] = lim_rd[1];
          isr_pkg::OP_RD_ESR: rd_val[gi] = standard_event_status;
          isr_pkg::OP_RD_ESE: rd_val[gi] = standard_event_enable;
          isr_pkg::OP_RD_EER: rd_val[gi] = execution_error_code;
          isr_pkg::OP_RD_STB: rd_val[gi] = stb_query;
          isr_pkg::OP_SPOLL:  rd_val[gi] = stb_poll;
          isr_pkg::OP_RD_SRE: rd_val[gi] = service_request_enable;
          default:            rd_val[gi] = isr_pkg::ZERO_BYTE;
        endcase
      end
    end
  endgenerate

endmodule : isr_status_top

// ==== testbench/isr_status_assertions.sv ====
// Port-level checks for the status reporting top.
// Assumes it is bound into isr_status_top; one clock, synchronous reset.
`timescale 1ns/1ps
module isr_status_assertions (
  input wire logic                                              core_clk,     // Clock
  input wire logic                                              rst,          // Reset
  input wire isr_pkg::isr_cmd_type                              cmd,          // Access
  input wire isr_pkg::isr_limit_evt_type [isr_pkg::NUM_OUT-1:0] limit_evt,    // Limit events
  input wire isr_pkg::isr_if_evt_type [isr_pkg::NUM_IF-1:0]     if_evt,       // Parser events
  input wire logic [7:0]                                        rsp_data,     // Read value
  input wire logic                                              rsp_valid,    // Read valid
  input wire logic [isr_pkg::NUM_IF-1:0]                        srq,          // Requests
  input wire logic [isr_pkg::NUM_IF-1:0]                        parser_reset  // Parser reset
);
  // Decode of the access presented this cycle
  wire live   = cmd.valid && (cmd.inst < 3'h5);
  wire rd_op  = live && (cmd.op inside {isr_pkg::OP_RD_LSR, isr_pkg::OP_RD_LSE,
    isr_pkg::OP_RD_ESR, isr_pkg::OP_RD_ESE, isr_pkg::OP_RD_EER, isr_pkg::OP_RD_STB,
    isr_pkg::OP_SPOLL, isr_pkg::OP_RD_SRE});
  wire wr_op  = live && (cmd.op inside {isr_pkg::OP_WR_LSE, isr_pkg::OP_WR_ESE,
    isr_pkg::OP_WR_EER, isr_pkg::OP_WR_SRE});
  wire stb_op = live && (cmd.op inside {isr_pkg::OP_RD_STB, isr_pkg::OP_SPOLL});
  wire poll0  = cmd.valid && (cmd.inst == 3'h0) && (cmd.op == isr_pkg::OP_SPOLL);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Answers, refusals and fixed-zero bits
  AST_READ_ANSWER: assert property (rd_op |=> rsp_valid)
    else $error("read without answer");
  AST_WRITE_SILENT: assert property (wr_op |=> !rsp_valid)
    else $error("write gave an answer");
  AST_FAR_INST: assert property (cmd.valid && (cmd.inst > 3'h4) |=> !rsp_valid)
    else $error("unknown instance answered");
  AST_STB_TOP_ZERO: assert property (stb_op |=> (rsp_data[7] == 1'b0))
    else $error("status byte bit 7 set");
  AST_ESR_FIXED: assert property (live && (cmd.op == isr_pkg::OP_RD_ESR) |=>
    (rsp_data[6] == 1'b0) && (rsp_data[1] == 1'b0)) else $error("event bits 6 or 1 set");
  AST_LSR_FIXED: assert property (live && (cmd.op == isr_pkg::OP_RD_LSR) |=>
    (rsp_data[7] == 1'b0) && (rsp_data[5] == 1'b0)) else $error("limit bits 7 or 5 set");
  // Parser reset follows exactly one syntax error
  AST_PARSER_RESET: assert property (if_evt[2].syntax_err |=> parser_reset[2])
    else $error("no parser reset");
  AST_PARSER_CAUSE: assert property (parser_reset[2] |-> $past(if_evt[2].syntax_err))
    else $error("parser reset without cause");
  // Request flag drops only through a poll
  AST_RQS_POLL: assert property ($fell(srq[0]) && !$past(rst) |-> $past(poll0))
    else $error("request dropped without poll");

  // Main scenarios
  cover property ($rose(srq[0]));
  cover property (parser_reset[2]);
  cover property (poll0 ##1 rsp_valid);
endmodule : isr_status_assertions

// ==== testbench/isr_ctl_model.sv ====
// Remote controller model: issues one register access and collects the answer.
// Assumes reads are answered on the taking edge itself and are still held at the following falling edge.
`timescale 1ns/1ps
module isr_ctl_model (
  input  wire logic           core_clk,   // Clock
  input  wire logic [7:0]     rsp_data,   // Read value
  input  wire logic           rsp_valid,  // Read valid
  output isr_pkg::isr_cmd_type cmd        // Access to device
);
  int unsigned gap = 0;  // Idle cycles before each access, less one

  initial cmd = '0;

  // Drive after a falling edge, hold over one taking edge, then release with scrambled fields
  task automatic issue(input logic [2:0] i, input isr_pkg::isr_op_type op,
    input logic [1:0] s, input logic [7:0] wd, output logic [7:0] d, output logic v);
    repeat (gap + 1) @(negedge core_clk);
    cmd = '{1'b1, i, op, s, wd};
    @(negedge core_clk);
    d = rsp_data;
    v = rsp_valid;
    cmd = {1'b0, ~cmd[$bits(cmd)-2:0]};
  endtask : issue
endmodule : isr_ctl_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the status reporting top.
// Assumes the controller model and the bound checker; short verify timeout.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [2:0]         i;
    isr_pkg::isr_op_type op;
    logic [1:0]         s;
    logic [7:0]         val;
    logic               rd;
  } isr_row_type;

  logic                                              core_clk  = 1'b0;
  logic                                              rst       = 1'b1;
  wire isr_pkg::isr_cmd_type                         cmd;
  isr_pkg::isr_limit_evt_type [isr_pkg::NUM_OUT-1:0] limit_evt = '0;
  isr_pkg::isr_if_evt_type [isr_pkg::NUM_IF-1:0]     if_evt    = '0;
  logic [7:0]                                        rsp_data;
  logic                                              rsp_valid;
  logic [isr_pkg::NUM_IF-1:0]                        srq;
  logic [isr_pkg::NUM_IF-1:0]                        parser_reset;
  int                                                failures  = 0;
  int                                                n_checks  = 0;
  int                                                pos [6]   = '{0, 1, 2, 3, 4, 6};
  logic [7:0]                                        codes [4] = '{8'h64, 8'h66, 8'h67, 8'hC8};
  isr_row_type                                       rows [14];

  isr_status_top #(.VERIFY_CYCLES(20)) u_dut (.core_clk(core_clk), .rst(rst), .cmd(cmd),
    .limit_evt(limit_evt), .if_evt(if_evt), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .srq(srq), .parser_reset(parser_reset));
  isr_ctl_model u_ctl (.core_clk(core_clk), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .cmd(cmd));

  // Clock, 40 ns period
  initial forever #20 core_clk = ~core_clk;

  // Compare tasks and verdict
  task automatic chk8(input logic [7:0] got, input logic [7:0] ex);
    n_checks++;
    if (got !== ex)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic ex);
    chk8({7'h00, got}, {7'h00, ex});
  endtask : chk1
  task automatic close_out;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if ((failures == 0) && (n_checks > 0))
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Register accesses and event pulses
  task automatic rd(input logic [2:0] i, input isr_pkg::isr_op_type op, input logic [1:0] s,
    input logic [7:0] ex);
    logic [7:0] d;
    logic       v;
    u_ctl.issue(i, op, s, 8'h00, d, v);
    chk1(v, 1'b1);
    chk8(d, ex);
  endtask : rd
  task automatic wr(input logic [2:0] i, input isr_pkg::isr_op_type op, input logic [1:0] s,
    input logic [7:0] wd);
    logic [7:0] d;
    logic       v;
    u_ctl.issue(i, op, s, wd, d, v);
    chk1(v, 1'b0);
  endtask : wr
  task automatic plim(input int k, input logic [5:0] b);
    @(negedge core_clk);
    limit_evt[k] = isr_pkg::isr_limit_evt_type'(b);
    @(negedge core_clk);
    limit_evt[k] = '0;
  endtask : plim
  task automatic pif(input int i, input logic [6:0] b);
    @(negedge core_clk);
    if_evt[i] = isr_pkg::isr_if_evt_type'(b);
    @(negedge core_clk);
    if_evt[i] = '0;
  endtask : pif

  // Hang guard
  initial
  begin
    #200us;
    failures++;
    close_out();
  end

  // Main sequence
  initial
  begin
    rows = '{'{0, isr_pkg::OP_RD_ESR, 0, 8'h80, 1}, '{0, isr_pkg::OP_RD_ESR, 0, 8'h00, 1},
      '{1, isr_pkg::OP_RD_ESR, 0, 8'h80, 1}, '{4, isr_pkg::OP_RD_ESR, 0, 8'h80, 1},
      '{0, isr_pkg::OP_RD_ESE, 0, 8'h00, 1}, '{0, isr_pkg::OP_RD_EER, 0, 8'h00, 1},
      '{0, isr_pkg::OP_RD_STB, 0, 8'h00, 1}, '{0, isr_pkg::OP_RD_SRE, 0, 8'h00, 1},
      '{0, isr_pkg::OP_WR_ESE, 0, 8'hFF, 0}, '{0, isr_pkg::OP_RD_ESE, 0, 8'hFF, 1},
      '{1, isr_pkg::OP_RD_ESE, 0, 8'h00, 1}, '{0, isr_pkg::OP_WR_ESE, 0, 8'h00, 0},
      '{0, isr_pkg::OP_WR_LSE, 3, 8'hA5, 0}, '{0, isr_pkg::OP_RD_LSE, 3, 8'hA5, 1}};
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    foreach (rows[r])
      if (rows[r].rd) rd(rows[r].i, rows[r].op, rows[r].s, rows[r].val);
      else wr(rows[r].i, rows[r].op, rows[r].s, rows[r].val);
    $display("end of table rows");
    wr(3'h5, isr_pkg::OP_RD_ESR, 2'h0, 8'h00);
    wr(3'h0, isr_pkg::OP_WR_LSE, 2'h3, 8'h00);
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < 6; j++)
      begin
        plim(k, 6'(1 << j));
        rd(3'h0, isr_pkg::OP_RD_LSR, 2'(k), 8'(1 << pos[j]));
        rd(3'h0, isr_pkg::OP_RD_LSR, 2'(k), 8'h00);
      end
    $display("end of limit bits");
    for (int k = 0; k < 4; k++)
    begin
      wr(3'h0, isr_pkg::OP_WR_LSE, 2'(k), 8'h02);
      plim(k, 6'h02);
      rd(3'h0, isr_pkg::OP_RD_STB, 2'h0, 8'(1 << k));
      wr(3'h0, isr_pkg::OP_WR_LSE, 2'(k), 8'h00);
      rd(3'h0, isr_pkg::OP_RD_STB, 2'h0, 8'h00);
      rd(3'h0, isr_pkg::OP_RD_LSR, 2'(k), 8'h02);
    end
    $display("end of limit summaries");
    pif(0, 7'h10);
    wr(3'h0, isr_pkg::OP_WR_ESE, 2'h0, 8'h01);
    rd(3'h0, isr_pkg::OP_RD_STB, 2'h0, 8'h20);
    chk1(srq[0], 1'b0);
    wr(3'h0, isr_pkg::OP_WR_SRE, 2'h0, 8'h20);
    @(negedge core_clk);
    chk1(srq[0], 1'b1);
    rd(3'h0, isr_pkg::OP_SPOLL, 2'h0, 8'h60);
    chk1(srq[0], 1'b0);
    rd(3'h0, isr_pkg::OP_SPOLL, 2'h0, 8'h20);
    rd(3'h0, isr_pkg::OP_RD_STB, 2'h0, 8'h60);
    rd(3'h0, isr_pkg::OP_RD_ESR, 2'h0, 8'h01);
    rd(3'h0, isr_pkg::OP_RD_STB, 2'h0, 8'h00);
    $display("end of service request");
    u_ctl.gap = 3;
    foreach (codes[c])
    begin
      wr(3'h1, isr_pkg::OP_WR_EER, 2'h0, codes[c]);
      rd(3'h1, isr_pkg::OP_RD_EER, 2'h0, codes[c]);
      rd(3'h1, isr_pkg::OP_RD_EER, 2'h0, 8'h00);
      rd(3'h1, isr_pkg::OP_RD_ESR, 2'h0, 8'h10);
    end
    wr(3'h1, isr_pkg::OP_WR_EER, 2'h0, 8'h00);
    rd(3'h1, isr_pkg::OP_RD_ESR, 2'h0, 8'h00);
    u_ctl.gap = 0;
    $display("end of error codes");
    pif(2, 7'h40);
    chk1(parser_reset[2], 1'b1);
    pif(2, 7'h20);
    chk1(parser_reset[2], 1'b0);
    rd(3'h2, isr_pkg::OP_RD_ESR, 2'h0, 8'hA4);
    pif(3, 7'h02);
    rd(3'h3, isr_pkg::OP_RD_STB, 2'h0, 8'h10);
    pif(3, 7'h01);
    rd(3'h3, isr_pkg::OP_RD_STB, 2'h0, 8'h00);
    $display("end of parser and message flag");
    pif(4, 7'h08);
    repeat (10) @(negedge core_clk);
    pif(4, 7'h04);
    repeat (30) @(negedge core_clk);
    rd(3'h4, isr_pkg::OP_RD_ESR, 2'h0, 8'h00);
    pif(4, 7'h08);
    repeat (25) @(negedge core_clk);
    rd(3'h4, isr_pkg::OP_RD_ESR, 2'h0, 8'h08);
    $display("end of verify timeout");
    close_out();
  end
endmodule : tb_top

bind isr_status_top isr_status_assertions u_chk (.core_clk(core_clk), .rst(rst), .cmd(cmd),
  .limit_evt(limit_evt), .if_evt(if_evt), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
  .srq(srq), .parser_reset(parser_reset));
